// ### logic/uart_async_receiver.sv
// Asynchronous serial receiver with an APB register file and a small receive buffer.
// Assumes an APB master on pclk and an unsynchronised serial input from a remote sender.
// Behaviour
// - Receive-complete flag is high exactly while the buffer holds an unread character.
// - Clearing receiver enable flushes the buffer so the receive-complete flag reads zero.
// - Interrupt requested while flag, its enable and global enable are all set.
// - Reading the data register returns the oldest character and frees its entry.
// - Each entry keeps its error flags; software reads them before the data.
// - Software writes to error flags are ignored; error flags raise no interrupt.
// - Frame error is one when the first stop bit sampled zero, whatever stop count.
// - Overrun when buffer full, a character waits, and a new start bit appears.
// - Overrun indication clears when the waiting frame moves into the buffer.
// - Parity checked only when parity enabled; odd select picks type; else flag zero.
// - Parity mismatch over data bits is stored with the character until read.
// - Disabling stops reception at once, drops partial frame, releases the input pin.
// - Sampling at sixteen times baud normally, eight times in double speed.
// - First low sample after idle high is one; samples 8-10 or 4-6 vote.
// - Majority-high start bit is noise and rejected; otherwise resynchronise and receive.
// - Sixteen or eight sample states per bit until the first stop bit.
// - Each data, parity and stop bit is a two-of-three majority vote.
// - Middle voting sample is nine normally and five in double speed.
// - Only the first stop bit is used; low stop sets frame error.
// - Next start edge accepted right after the last stop voting sample.
//
// Local design decisions: the register offsets and the APB interface to the registers.
`include "uart_rx_regs.svh"
module uart_async_receiver
  import uart_rx_pkg::*;
#(
  parameter int BUF_DEPTH = 2,
  parameter int BAUD_W    = 12
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_input_pin,
  input  wire logic        global_irq_enable,
  output logic             rx_irq,
  output logic             serial_pin_override
);

  localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam logic [PTR_W:0] FULL_COUNT = BUF_DEPTH[PTR_W:0];

  // The pointer arithmetic wraps naturally only for power-of-two depths.
  if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("BUF_DEPTH must be a power of two of at least 2");
  end
  if (BAUD_W < 1 || BAUD_W > 16)
  begin : g_bad_baud
    $error("BAUD_W must lie between 1 and 16");
  end

  logic [1:0]        rx_sync, next_rx_sync, size, next_size, votes, next_votes;
  logic              rx_s, tick, access, hit, pop, push, full, rxc, vote;
  logic              rx_en, next_rx_en, rxc_ie, next_rxc_ie, double_speed, next_double_speed;
  logic              par_en, next_par_en, par_odd, next_par_odd, stop2, next_stop2;
  logic              par_bit, next_par_bit, prev_rx, next_prev_rx, pend_v, next_pend_v;
  logic              ovr_pend, next_ovr_pend, pop_armed, next_pop_armed;
  logic [BAUD_W-1:0] baud_div, next_baud_div, baud_cnt, next_baud_cnt;
  rx_state_t         state, next_state;
  logic [4:0]        smp, next_smp, osr, mid;
  logic [3:0]        bit_idx, next_bit_idx, nbits, last_idx;
  logic [7:0]        shreg, next_shreg;
  logic [31:0]       next_prdata;
  rx_entry_t         pend, next_pend, head, push_entry;
  rx_entry_t         mem [BUF_DEPTH];
  rx_entry_t         next_mem [BUF_DEPTH];
  logic [PTR_W-1:0]  wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [PTR_W:0]    count, next_count;

  // Bus decode; the slave never inserts wait states.
  assign pready  = 1'b1;
  assign access  = psel & penable;
  assign hit     = (paddr == `OFS_DATA) || (paddr == `OFS_STATUS) || (paddr == `OFS_CTRL)
                || (paddr == `OFS_FORMAT) || (paddr == `OFS_BAUD);
  assign pslverr = access & ~hit;
  // Pop only if data was present when the read began, so the sampled word is what leaves.
  assign pop     = access & ~pwrite & (paddr == `OFS_DATA) & pop_armed;

  // Buffer status and frame geometry.
  assign full       = (count == FULL_COUNT);
  assign rxc        = rx_en & (count != '0);
  assign head       = mem[rd_ptr];
  assign push       = rx_en & pend_v & (~full | pop);
  assign push_entry = '{data: pend.data, frame_err: pend.frame_err,
                        overrun: ovr_pend, parity_err: pend.parity_err};
  assign osr        = double_speed ? `OSR_DOUBLE : `OSR_NORMAL;
  assign mid        = double_speed ? `MID_DOUBLE : `MID_NORMAL;
  assign nbits      = `DATA_BITS_MIN + {2'b00, size};
  assign last_idx   = nbits + {3'b000, par_en};
  // Two of three: the two stored samples and the one arriving now.
  assign vote       = (votes[1] & votes[0]) | (votes[1] & rx_s) | (votes[0] & rx_s);

  // The interrupt is a level, so it stays asserted until the buffer drains.
  assign rx_irq              = rxc & rxc_ie & global_irq_enable;
  assign serial_pin_override = rx_en;

  // Two-stage synchroniser; only the second stage feeds the receiver.
  always_comb
  begin
    next_rx_sync = {rx_sync[0], serial_input_pin};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_sync <= 2'b11;
    else
      rx_sync <= next_rx_sync;
  end

  assign rx_s = rx_sync[1];

  // Configuration registers; the error bits of the status word are not writable.
  always_comb
  begin
    {next_rx_en, next_rxc_ie, next_double_speed} = {rx_en, rxc_ie, double_speed};
    {next_par_en, next_par_odd, next_stop2}      = {par_en, par_odd, stop2};
    next_size     = size;
    next_baud_div = baud_div;
    if (access && pwrite)
    begin
      unique case (paddr)
        `OFS_STATUS: next_double_speed = pwdata[`BIT_DOUBLE_SPEED];
        `OFS_CTRL:
        begin
          next_rx_en  = pwdata[`BIT_RX_EN];
          next_rxc_ie = pwdata[`BIT_RXC_IE];
        end
        `OFS_FORMAT:
        begin
          next_par_en  = pwdata[`BIT_PAR_EN];
          next_par_odd = pwdata[`BIT_PAR_ODD];
          next_stop2   = pwdata[`BIT_STOP2];
          next_size    = pwdata[`SIZE_LSB +: 2];
        end
        `OFS_BAUD:   next_baud_div = pwdata[BAUD_W-1:0];
        default:     next_rx_en = rx_en;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {rx_en, rxc_ie, double_speed, par_en, par_odd, stop2} <= 6'h00;
      size     <= `RST_SIZE;
      baud_div <= BAUD_W'(`RST_BAUD);
    end
    else
    begin
      {rx_en, rxc_ie, double_speed, par_en, par_odd, stop2} <=
        {next_rx_en, next_rxc_ie, next_double_speed, next_par_en, next_par_odd, next_stop2};
      size     <= next_size;
      baud_div <= next_baud_div;
    end
  end

  // Sample tick: one pulse every baud_div + 1 clocks while the receiver is on.
  assign tick = rx_en & (baud_cnt == '0);

  always_comb
  begin
    if (!rx_en || baud_cnt == '0)
      next_baud_cnt = baud_div;
    else
      next_baud_cnt = baud_cnt - 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      baud_cnt <= '0;
    else
      baud_cnt <= next_baud_cnt;
  end

  // Clock and data recovery. smp is the number of the previous sample, so rx_s
  // is sample smp + 1; votes therefore fall on smp = mid - 2, mid - 1 and mid.
  always_comb
  begin
    next_state = state;
    {next_smp, next_bit_idx, next_shreg, next_par_bit, next_votes, next_prev_rx} =
      {smp, bit_idx, shreg, par_bit, votes, prev_rx};
    {next_pend, next_pend_v, next_ovr_pend} = {pend, pend_v, ovr_pend};
    if (push)
    begin
      next_pend_v   = 1'b0;
      next_ovr_pend = 1'b0;
    end
    if (!rx_en)
    begin
      next_state    = ST_IDLE;
      next_smp      = 5'h00;
      next_pend_v   = 1'b0;
      next_ovr_pend = 1'b0;
      next_prev_rx  = 1'b1;
    end
    else if (tick)
    begin
      next_prev_rx = rx_s;
      if (state != ST_IDLE)
      begin
        next_smp = (smp == osr) ? 5'h01 : smp + 5'h01;
        if (smp == mid - 5'h02 || smp == mid - 5'h01)
          next_votes = {votes[0], rx_s};
      end
      unique case (state)
        ST_IDLE:
        begin
          if (prev_rx && !rx_s)
          begin
            next_state = ST_START;
            next_smp   = 5'h01;
            if (pend_v && full)
              next_ovr_pend = 1'b1;
          end
        end
        ST_START:
        begin
          if (smp == mid && vote)
            next_state = ST_IDLE;
          else if (smp == osr)
          begin
            next_state   = ST_BITS;
            next_bit_idx = 4'h0;
            next_shreg   = 8'h00;
            next_par_bit = 1'b0;
          end
        end
        ST_BITS:
        begin
          if (smp == mid)
          begin
            if (bit_idx < nbits)
              next_shreg[bit_idx[2:0]] = vote;
            else if (par_en && bit_idx == nbits)
              next_par_bit = vote;
            if (bit_idx == last_idx)
            begin
              // The stop is decided here; the rest of the stop time is not waited.
              next_state = ST_IDLE;
              if (!next_pend_v)
              begin
                next_pend_v          = 1'b1;
                next_pend.data       = shreg;
                next_pend.frame_err  = ~vote;
                next_pend.overrun    = 1'b0;
                next_pend.parity_err = par_en & (^shreg ^ par_bit ^ par_odd);
              end
            end
          end
          else if (smp == osr)
            next_bit_idx = bit_idx + 4'h1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_IDLE;
      {smp, bit_idx, shreg, par_bit, votes, prev_rx} <= {5'h00, 4'h0, 8'h00, 1'b0, 2'b11, 1'b1};
      {pend, pend_v, ovr_pend} <= {11'h000, 2'b00};
    end
    else
    begin
      state <= next_state;
      {smp, bit_idx, shreg, par_bit, votes, prev_rx} <=
        {next_smp, next_bit_idx, next_shreg, next_par_bit, next_votes, next_prev_rx};
      {pend, pend_v, ovr_pend} <= {next_pend, next_pend_v, next_ovr_pend};
    end
  end

  // Receive buffer; disabling the receiver empties it at once.
  always_comb
  begin
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (!rx_en)
    begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end
    else
    begin
      if (push)
      begin
        next_mem[wr_ptr] = push_entry;
        next_wr_ptr      = wr_ptr + 1'b1;
      end
      if (pop)
        next_rd_ptr = rd_ptr + 1'b1;
      if (push && !pop)
        next_count = count + 1'b1;
      else if (pop && !push)
        next_count = count - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < BUF_DEPTH; i++)
        mem[i] <= '0;
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      mem    <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Read data is captured in the setup phase so that it comes from a flip-flop.
  always_comb
  begin
    next_prdata    = prdata;
    next_pop_armed = 1'b0;
    if (psel && !penable && !pwrite)
    begin
      next_prdata = 32'h0000_0000;
      unique case (paddr)
        `OFS_DATA:
        begin
          next_pop_armed = rxc;
          if (rxc)
            next_prdata[7:0] = head.data;
        end
        `OFS_STATUS:
        begin
          next_prdata[`BIT_RXC]          = rxc;
          next_prdata[`BIT_FE]           = rxc & head.frame_err;
          next_prdata[`BIT_DOR]          = rxc & head.overrun;
          next_prdata[`BIT_UPE]          = rxc & par_en & head.parity_err;
          next_prdata[`BIT_DOUBLE_SPEED] = double_speed;
        end
        `OFS_CTRL:
        begin
          next_prdata[`BIT_RX_EN]  = rx_en;
          next_prdata[`BIT_RXC_IE] = rxc_ie;
        end
        `OFS_FORMAT:
        begin
          next_prdata[`BIT_PAR_EN]    = par_en;
          next_prdata[`BIT_PAR_ODD]   = par_odd;
          next_prdata[`BIT_STOP2]     = stop2;
          next_prdata[`SIZE_LSB +: 2] = size;
        end
        `OFS_BAUD:   next_prdata[BAUD_W-1:0] = baud_div;
        default:     next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {prdata, pop_armed} <= {32'h0000_0000, 1'b0};
    else
      {prdata, pop_armed} <= {next_prdata, next_pop_armed};
  end

endmodule : uart_async_receiver

// ### logic/uart_rx_regs.svh
// Register offsets, field positions, reset values and sampling counts of the receiver.
// Assumes an 8-bit APB byte address; every register is one aligned 32-bit word.
`ifndef UART_RX_REGS_SVH
`define UART_RX_REGS_SVH

`define OFS_DATA          8'h00
`define OFS_STATUS        8'h04
`define OFS_CTRL          8'h08
`define OFS_FORMAT        8'h0C
`define OFS_BAUD          8'h10

`define BIT_RXC           7
`define BIT_FE            4
`define BIT_DOR           3
`define BIT_UPE           2
`define BIT_DOUBLE_SPEED  1
`define BIT_RXC_IE        7
`define BIT_RX_EN         4
`define BIT_PAR_EN        5
`define BIT_PAR_ODD       4
`define BIT_STOP2         3
`define SIZE_LSB          1

`define RST_SIZE          2'h3
`define RST_BAUD          12'h000

`define OSR_NORMAL        5'h10
`define OSR_DOUBLE        5'h08
`define MID_NORMAL        5'h09
`define MID_DOUBLE        5'h05
`define DATA_BITS_MIN     4'h5

`endif

// ### logic/uart_rx_pkg.sv
// Types shared by the asynchronous receiver.
// Assumes nothing beyond a SystemVerilog compiler.
package uart_rx_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BITS} rx_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic       frame_err;
    logic       overrun;
    logic       parity_err;
  } rx_entry_t;

endpackage : uart_rx_pkg

// ### tb/uart_line_sender.sv
// Model of the remote asynchronous sender on the receiver's serial input.
// Assumes the bench calls its tasks; one sample tick per pclk (baud divisor 0).
module uart_line_sender
(
  input  wire logic pclk,
  output logic      line
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle line is high, as a pulled-up serial line is between frames.
  initial line = 1'b1;

  // Holds one level for n clocks, changing it just after a rising edge.
  task automatic put(input logic b, input int n);
    repeat (n) @(posedge pclk) line <= b;
  endtask : put

  // Start bit, data LSB first, optional parity, then one stop bit of the given level.
  task automatic send_frame(input logic [7:0] d, input int nb, input logic pon,
                            input logic par, input logic stop, input int spb);
    put(1'b0, spb);
    for (int i = 0; i < nb; i++)
      put(d[i], spb);
    if (pon)
      put(par, spb);
    put(stop, spb);
    // A low stop is a break; the line must rise again before a new edge can exist.
    if (!stop)
      put(1'b1, spb);
  endtask : send_frame
endmodule : uart_line_sender

// ### tb/uart_async_receiver_monitor.sv
// Concurrent checks on the receiver's ports.
// Assumes the register map of uart_rx_regs.svh and zero-wait APB.
`include "uart_rx_regs.svh"
module uart_async_receiver_monitor
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        serial_input_pin,
  input wire logic        global_irq_enable,
  input wire logic        rx_irq,
  input wire logic        serial_pin_override
);
  logic ie_sh, en_sh, par_sh;
  logic next_ie_sh, next_en_sh, next_par_sh;
  logic wr, rd_st, rd_dat;

  // Access-phase decodes.
  assign wr     = psel && penable && pwrite;
  assign rd_st  = psel && penable && !pwrite && paddr == `OFS_STATUS;
  assign rd_dat = psel && penable && !pwrite && paddr == `OFS_DATA;

  // Shadows of control bits, so the flag can be judged from outside.
  always_comb
  begin
    next_ie_sh  = ie_sh;
    next_en_sh  = en_sh;
    next_par_sh = par_sh;
    if (wr && paddr == `OFS_CTRL)
    begin
      next_ie_sh = pwdata[`BIT_RXC_IE];
      next_en_sh = pwdata[`BIT_RX_EN];
    end
    if (wr && paddr == `OFS_FORMAT)
      next_par_sh = pwdata[`BIT_PAR_EN];
  end

  // Shadow registers follow the design's reset values.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {ie_sh, en_sh, par_sh} <= 3'h0;
    else
      {ie_sh, en_sh, par_sh} <= {next_ie_sh, next_en_sh, next_par_sh};
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_irq_gated;
    !global_irq_enable |-> !rx_irq;
  endproperty
  a_irq_gated: assert property (p_irq_gated)
    else $error("interrupt without global enable");
  property p_irq_needs_ie;
    !ie_sh |-> !rx_irq;
  endproperty
  a_irq_needs_ie: assert property (p_irq_needs_ie)
    else $error("interrupt without its enable");
  property p_flush_read;
    rd_st && $past(!en_sh) |-> prdata[7] == 1'b0 && prdata[4:2] == 3'h0;
  endproperty
  a_flush_read: assert property (p_flush_read)
    else $error("status not empty while receiver off");
  property p_pin_release;
    wr && paddr == `OFS_CTRL |=> serial_pin_override == $past(pwdata[`BIT_RX_EN]);
  endproperty
  a_pin_release: assert property (p_pin_release)
    else $error("pin override does not follow enable");
  property p_flag_vs_irq;
    rd_st && $past(ie_sh && global_irq_enable) |-> prdata[7] == $past(rx_irq);
  endproperty
  a_flag_vs_irq: assert property (p_flag_vs_irq)
    else $error("flag and interrupt disagree");
  property p_parity_off;
    rd_st && $past(!par_sh) |-> prdata[2] == 1'b0;
  endproperty
  a_parity_off: assert property (p_parity_off)
    else $error("parity error while checking off");
  property p_empty_data;
    rd_dat && $past(ie_sh && global_irq_enable && !rx_irq) |-> prdata == 32'h0;
  endproperty
  a_empty_data: assert property (p_empty_data)
    else $error("data read from empty buffer not zero");
  property p_irq_needs_rx;
    rx_irq |-> serial_pin_override;
  endproperty
  a_irq_needs_rx: assert property (p_irq_needs_rx)
    else $error("interrupt while receiver off");
endmodule : uart_async_receiver_monitor

bind uart_async_receiver uart_async_receiver_monitor mon_u
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .serial_input_pin, .global_irq_enable, .rx_irq, .serial_pin_override
);

// ### tb/uart_async_receiver_bench.sv
// Self-checking bench: APB register tests and serial frames from the sender model.
// Assumes baud divisor 0, so one sample per pclk and 16 or 8 clocks per bit.
`include "uart_rx_regs.svh"
module uart_async_receiver_bench import uart_rx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        serial_input_pin;
  logic        global_irq_enable = 1'b1;
  logic        rx_irq;
  logic        serial_pin_override;
  logic [31:0] rdat;
  logic        rerr;
  int          n_mismatch = 0;
  int          checks = 0;
  int          cyc = 0;

  uart_async_receiver dut_u
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .serial_input_pin, .global_irq_enable, .rx_irq, .serial_pin_override
  );
  uart_line_sender snd_u (.pclk(pclk), .line(serial_input_pin));

  always #50 pclk = ~pclk;

  // Cuts a hang short; the frames need far fewer cycles than this.
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // One APB transfer; the request stands until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rdat, x);
  endtask : rd

  // Polls the status word until the receive-complete bit shows.
  task automatic wait_rx;
    int n;
    n = 0;
    rdat = 32'h0;
    while (rdat[`BIT_RXC] !== 1'b1 && n < 300)
    begin
      apb(1'b0, `OFS_STATUS, 32'h0);
      n++;
    end
  endtask : wait_rx

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  // Main sequence.
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFS_FORMAT, 32'h06);
    rd(`OFS_CTRL, 32'h0);
    rd(`OFS_STATUS, 32'h0);
    rd(`OFS_DATA, 32'h0);
    rd(8'h20, 32'h0);
    chk(rerr, 1'b1);
    apb(1'b1, `OFS_BAUD, 32'h123);
    rd(`OFS_BAUD, 32'h123);
    apb(1'b1, `OFS_BAUD, 32'h0);
    done("reset");
    apb(1'b1, `OFS_CTRL, 32'h90);
    snd_u.send_frame(8'hA5, 8, 1'b0, 1'b0, 1'b1, 16);
    wait_rx();
    chk(rx_irq, 1'b1);
    @(posedge pclk) global_irq_enable <= 1'b0;
    @(posedge pclk);
    chk(rx_irq, 1'b0);
    global_irq_enable <= 1'b1;
    rd(`OFS_DATA, 32'hA5);
    rd(`OFS_STATUS, 32'h0);
    rd(`OFS_DATA, 32'h0);
    done("single");
    snd_u.send_frame(8'h11, 8, 1'b0, 1'b0, 1'b1, 16);
    snd_u.send_frame(8'h22, 8, 1'b0, 1'b0, 1'b1, 16);
    snd_u.send_frame(8'h33, 8, 1'b0, 1'b0, 1'b1, 16);
    snd_u.send_frame(8'h44, 8, 1'b0, 1'b0, 1'b1, 16);
    repeat (20) @(posedge pclk);
    rd(`OFS_STATUS, 32'h80);
    rd(`OFS_DATA, 32'h11);
    rd(`OFS_STATUS, 32'h80);
    rd(`OFS_DATA, 32'h22);
    rd(`OFS_STATUS, 32'h88);
    rd(`OFS_DATA, 32'h33);
    rd(`OFS_STATUS, 32'h0);
    done("overrun");
    apb(1'b1, `OFS_FORMAT, 32'h0E);
    snd_u.send_frame(8'h3C, 8, 1'b0, 1'b0, 1'b0, 16);
    wait_rx();
    chk(rdat, 32'h90);
    rd(`OFS_DATA, 32'h3C);
    done("frame error");
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, `OFS_FORMAT, 32'h26 | (k[1] << `BIT_PAR_ODD));
      snd_u.send_frame(8'h03, 8, 1'b1, k[1] ^ k[0], 1'b1, 16);
      wait_rx();
      chk(rdat, 32'h80 | (k[0] << `BIT_UPE));
      rd(`OFS_DATA, 32'h03);
    end
    apb(1'b1, `OFS_FORMAT, 32'h06);
    snd_u.send_frame(8'h07, 8, 1'b0, 1'b0, 1'b1, 16);
    wait_rx();
    chk(rdat, 32'h80);
    rd(`OFS_DATA, 32'h07);
    apb(1'b1, `OFS_FORMAT, 32'h00);
    snd_u.send_frame(8'hF5, 5, 1'b0, 1'b0, 1'b1, 16);
    wait_rx();
    rd(`OFS_DATA, 32'h15);
    apb(1'b1, `OFS_FORMAT, 32'h06);
    done("parity and size");
    apb(1'b1, `OFS_STATUS, 32'h02);
    snd_u.send_frame(8'h5A, 8, 1'b0, 1'b0, 1'b1, 8);
    wait_rx();
    chk(rdat, 32'h82);
    rd(`OFS_DATA, 32'h5A);
    apb(1'b1, `OFS_STATUS, 32'h00);
    done("double speed");
    snd_u.put(1'b0, 3);
    snd_u.put(1'b1, 20);
    snd_u.send_frame(8'hC3, 8, 1'b0, 1'b0, 1'b1, 16);
    wait_rx();
    rd(`OFS_DATA, 32'hC3);
    rd(`OFS_STATUS, 32'h0);
    done("noise");
    snd_u.send_frame(8'h77, 8, 1'b0, 1'b0, 1'b1, 16);
    wait_rx();
    apb(1'b1, `OFS_CTRL, 32'h80);
    @(posedge pclk);
    chk(rx_irq, 1'b0);
    chk(serial_pin_override, 1'b0);
    rd(`OFS_STATUS, 32'h0);
    apb(1'b1, `OFS_CTRL, 32'h90);
    fork
      snd_u.send_frame(8'hFF, 8, 1'b0, 1'b0, 1'b1, 16);
      begin
        repeat (60) @(posedge pclk);
        apb(1'b1, `OFS_CTRL, 32'h80);
        apb(1'b1, `OFS_CTRL, 32'h90);
      end
    join
    repeat (40) @(posedge pclk);
    rd(`OFS_STATUS, 32'h0);
    done("disable");
    print_verdict();
  end
endmodule : uart_async_receiver_bench
